// >>> eis_pkg.sv
/*
  eis_pkg: constants and types shared by the interrupt summary and
  time-out counter block.
  assumes: included before eis_irq_summary.sv; one clock, one reset.
*/
`default_nettype none
package eis_pkg;

  // ****************************************************************
  // register map (word aligned byte addresses)
  // ****************************************************************
  localparam logic [7:0]  EIS_OFS_SUMMARY  = 8'h00;
  localparam logic [7:0]  EIS_OFS_COUNTER  = 8'h04;
  localparam logic [7:0]  EIS_OFS_CONTROL  = 8'h08;
  localparam logic [7:0]  EIS_OFS_EVT_STAT = 8'h0C;
  localparam logic [7:0]  EIS_OFS_EVT_MASK = 8'h10;
  localparam int          EIS_ADDR_W       = 8;

  // ****************************************************************
  // summary register field positions
  // ****************************************************************
  localparam int          EIS_DESC_LO      = 17;
  localparam int          EIS_DESC_HI      = 31;
  localparam int          EIS_BIT_TSYNC    = 13;
  localparam int          EIS_BIT_RXWARN   = 12;
  localparam int          EIS_BIT_STWARN   = 9;
  localparam int          EIS_BIT_STUPD    = 8;
  localparam int          EIS_BIT_MAC      = 7;
  localparam int          EIS_BIT_ERR      = 6;
  localparam int          EIS_BIT_SENT     = 2;
  localparam int          EIS_BIT_GOT      = 0;
  localparam logic [31:0] EIS_RSVD_MASK    = 32'h0001_CC3A;

  // ****************************************************************
  // counter, control and event register layout
  // ****************************************************************
  localparam int          EIS_CNT_W        = 16;
  localparam logic [15:0] EIS_CNT_MAX      = 16'hFFFF;
  localparam int          EIS_CTL_CLRMODE  = 0;
  localparam int          EIS_EVT_W        = 3;
  localparam int          EIS_EVT_PENDING  = 0;
  localparam int          EIS_EVT_TIMEOUT  = 1;
  localparam int          EIS_EVT_SATURATE = 2;

  // ****************************************************************
  // source widths
  // ****************************************************************
  localparam int          EIS_DESC_N       = 16;
  localparam int          EIS_TSYNC_W      = 32;
  localparam int          EIS_ERR_W        = 32;
  localparam int          EIS_TXQ_N        = 4;
  localparam int          EIS_RXQ_N        = 18;

  // ahb transfer types
  localparam logic [1:0]  EIS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  EIS_HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic [EIS_DESC_N-1:0]  descriptor_enable_reg;
    logic [EIS_DESC_N-1:0]  descriptor_flag_reg;
    logic [EIS_TSYNC_W-1:0] time_sync_enable_reg;
    logic [EIS_TSYNC_W-1:0] time_sync_flag_reg;
    logic                   rx_fifo_warn_enable;
    logic                   rx_fifo_warn_flag;
    logic                   stamp_fifo_warn_enable;
    logic                   stamp_fifo_warn_flag;
    logic                   stamp_fifo_update_enable;
    logic                   stamp_fifo_update_flag;
    logic                   mac_core_irq;
    logic [EIS_ERR_W-1:0]   error_enable_reg;
    logic [EIS_ERR_W-1:0]   error_flag_reg;
    logic [EIS_TXQ_N-1:0]   frame_sent_enable;
    logic [EIS_TXQ_N-1:0]   frame_sent_flag;
    logic [EIS_RXQ_N-1:0]   frame_got_enable;
    logic [EIS_RXQ_N-1:0]   frame_got_flag;
  } eis_src_s;

  typedef enum logic [1:0] {
    EIS_PH_IDLE  = 2'b00,
    EIS_PH_READ  = 2'b01,
    EIS_PH_WRITE = 2'b10
  } eis_phase_e;

endpackage
`default_nettype wire

// >>> eis_irq_summary.sv
/*
  eis_irq_summary: interrupt summary status register and transmit
  time-out frame counter, reached over an ahb-lite slave port.
  assumes: all source inputs and timeout_event come from logic on hclk;
  the ahb master issues single word transfers only.
*/
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - summary bits 31..17 show descriptor enable and flag both set, per index
// - reserved summary bits 16..14, 11, 10, 5..3 and 1 read zero
// - bit 13 set when any time-sync enable or flag bit is set
// - bit 12 shows receive fifo warning enable and flag both set
// - bit 9 shows time-stamp fifo warning enable and flag both set
// - bit 8 shows time-stamp fifo update enable and flag both set
// - bit 7 set while the mac core raises its interrupt
// - bit 6 set when any error flag bit meets its enable bit
// - bit 2 set when any transmit queue has sent enable and flag set
// - bit 0 set when any receive queue has got enable and flag set
// - 16-bit counter in bits 15..0 counts transmitted frames that timed out
// - counter stops at its maximum, further time-outs change nothing
// - clear mode one: reading the counter returns it, then clears it
// - clear mode zero: any counter write clears it, reads leave it
// - counter bits 31..16 read zero; software writes zero there
module eis_irq_summary #(
  parameter int CNT_W = 16
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output var  logic [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire eis_pkg::eis_src_s src,
  input  wire logic            timeout_event,
  output logic                 irq
);
  import eis_pkg::*;

  // refused at elaboration: the count field holds at most 16 bits
  if (CNT_W < 1 || CNT_W > EIS_CNT_W) begin : g_bad_cnt_w
    $error("CNT_W must lie between 1 and 16");
  end

  // ****************************************************************
  // summary decode
  // ****************************************************************
  function automatic logic [31:0] summary_of(input eis_src_s s);
    logic [31:0] v;
    v = '0;
    for (int i = 1; i < EIS_DESC_N; i++) begin
      v[EIS_DESC_LO+i-1] = s.descriptor_enable_reg[i] & s.descriptor_flag_reg[i];
    end
    v[EIS_BIT_TSYNC]  = |{s.time_sync_enable_reg, s.time_sync_flag_reg};
    v[EIS_BIT_RXWARN] = s.rx_fifo_warn_enable & s.rx_fifo_warn_flag;
    v[EIS_BIT_STWARN] = s.stamp_fifo_warn_enable & s.stamp_fifo_warn_flag;
    v[EIS_BIT_STUPD]  = s.stamp_fifo_update_enable & s.stamp_fifo_update_flag;
    v[EIS_BIT_MAC]    = s.mac_core_irq;
    v[EIS_BIT_ERR]    = |(s.error_enable_reg & s.error_flag_reg);
    v[EIS_BIT_SENT]   = |(s.frame_sent_enable & s.frame_sent_flag);
    v[EIS_BIT_GOT]    = |(s.frame_got_enable & s.frame_got_flag);
    return v & ~EIS_RSVD_MASK;
  endfunction

  logic [31:0] summary;
  assign summary = summary_of(src);

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  // zero wait states: read data is prepared at the address phase edge
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic                  take;
  logic                  rd_take;
  logic [EIS_ADDR_W-1:0] a_ofs;
  eis_phase_e            phase;
  logic [EIS_ADDR_W-1:0] ph_ofs;

  assign take    = hsel & hready & (htrans == EIS_HTRANS_NONSEQ || htrans == EIS_HTRANS_SEQ);
  assign rd_take = take & ~hwrite;
  assign a_ofs   = haddr[EIS_ADDR_W-1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase  <= EIS_PH_IDLE;
      ph_ofs <= '0;
    end else if (hready) begin
      phase  <= !take ? EIS_PH_IDLE : (hwrite ? EIS_PH_WRITE : EIS_PH_READ);
      ph_ofs <= a_ofs;
    end
  end

  logic wr_ctl;
  logic wr_cnt;
  logic wr_mask;
  logic rd_cnt;
  logic rd_stat;

  assign wr_ctl  = (phase == EIS_PH_WRITE) && (ph_ofs == EIS_OFS_CONTROL);
  assign wr_cnt  = (phase == EIS_PH_WRITE) && (ph_ofs == EIS_OFS_COUNTER);
  assign wr_mask = (phase == EIS_PH_WRITE) && (ph_ofs == EIS_OFS_EVT_MASK);
  assign rd_cnt  = rd_take && (a_ofs == EIS_OFS_COUNTER);
  assign rd_stat = rd_take && (a_ofs == EIS_OFS_EVT_STAT);

  // ****************************************************************
  // control and mask registers
  // ****************************************************************
  logic                 clear_mode;
  logic [EIS_EVT_W-1:0] evt_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_mode <= 1'b0;
    end else if (wr_ctl) begin
      clear_mode <= hwdata[EIS_CTL_CLRMODE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_mask <= '0;
    end else if (wr_mask) begin
      evt_mask <= hwdata[EIS_EVT_W-1:0];
    end
  end

  // ****************************************************************
  // time-out frame counter
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_TOP = EIS_CNT_MAX[CNT_W-1:0];

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             cnt_clear;
  logic             cnt_step;

  // a time-out in the clearing cycle is kept: it counts from zero
  assign cnt_clear = clear_mode ? rd_cnt : wr_cnt;
  assign cnt_step  = timeout_event && (cnt_clear || count != CNT_TOP);

  always_comb begin
    next_count = cnt_clear ? '0 : count;
    if (cnt_step) begin
      next_count = next_count + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ****************************************************************
  // sticky events and interrupt
  // ****************************************************************
  logic                 pend_q;
  logic [EIS_EVT_W-1:0] evt_stat;
  logic [EIS_EVT_W-1:0] evt_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= |summary;
    end
  end

  always_comb begin
    evt_set                   = '0;
    evt_set[EIS_EVT_PENDING]  = (|summary) & ~pend_q;
    evt_set[EIS_EVT_TIMEOUT]  = cnt_step;
    evt_set[EIS_EVT_SATURATE] = cnt_step && (next_count == CNT_TOP);
  end

  // set beats the clear of a read in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_stat <= '0;
    end else begin
      evt_stat <= (rd_stat ? '0 : evt_stat) | evt_set;
    end
  end

  assign irq = |(evt_stat & evt_mask);

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_take) begin
      if (a_ofs == EIS_OFS_SUMMARY) begin
        hrdata <= summary;
      end else if (a_ofs == EIS_OFS_COUNTER) begin
        hrdata <= 32'(count);
      end else if (a_ofs == EIS_OFS_CONTROL) begin
        hrdata <= 32'(clear_mode);
      end else if (a_ofs == EIS_OFS_EVT_STAT) begin
        hrdata <= 32'(evt_stat);
      end else if (a_ofs == EIS_OFS_EVT_MASK) begin
        hrdata <= 32'(evt_mask);
      end else begin
        hrdata <= '0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_sum;
  logic rd_cnt_q;
  assign rd_sum = rd_take && (a_ofs == EIS_OFS_SUMMARY);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt_q <= 1'b0;
    end else begin
      rd_cnt_q <= rd_cnt;
    end
  end

  property p_desc;
    src.descriptor_enable_reg[5] && src.descriptor_flag_reg[5] |-> summary[21];
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor summary bit missing");

  // descriptor indices 1 to 15 at once, both directions
  property p_desc_all;
    summary[EIS_DESC_HI:EIS_DESC_LO] ==
      (src.descriptor_enable_reg[EIS_DESC_N-1:1] & src.descriptor_flag_reg[EIS_DESC_N-1:1]);
  endproperty
  a_desc_all: assert property (p_desc_all) else $error("descriptor summary wrong");

  property p_rsvd;
    rd_sum |=> (hrdata & EIS_RSVD_MASK) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved summary bit read nonzero");

  property p_rsvd_live;
    (summary & EIS_RSVD_MASK) == 32'h0000_0000;
  endproperty
  a_rsvd_live: assert property (p_rsvd_live) else $error("reserved summary bit set");

  property p_tsync;
    (|src.time_sync_flag_reg) |-> summary[EIS_BIT_TSYNC];
  endproperty
  a_tsync: assert property (p_tsync) else $error("time-sync summary missing");

  property p_tsync_en;
    (|src.time_sync_enable_reg) |-> summary[EIS_BIT_TSYNC];
  endproperty
  a_tsync_en: assert property (p_tsync_en) else $error("time-sync enable not summed");

  property p_rxwarn;
    summary[EIS_BIT_RXWARN] == (src.rx_fifo_warn_enable && src.rx_fifo_warn_flag);
  endproperty
  a_rxwarn: assert property (p_rxwarn) else $error("rx warn summary wrong");

  property p_stwarn;
    summary[EIS_BIT_STWARN] == (src.stamp_fifo_warn_enable && src.stamp_fifo_warn_flag);
  endproperty
  a_stwarn: assert property (p_stwarn) else $error("stamp warn summary wrong");

  property p_stupd;
    summary[EIS_BIT_STUPD] == (src.stamp_fifo_update_enable && src.stamp_fifo_update_flag);
  endproperty
  a_stupd: assert property (p_stupd) else $error("stamp update summary wrong");

  property p_mac;
    rd_sum && src.mac_core_irq |=> hrdata[EIS_BIT_MAC];
  endproperty
  a_mac: assert property (p_mac) else $error("mac summary not read back");

  property p_err;
    summary[EIS_BIT_ERR] |-> (|(src.error_enable_reg & src.error_flag_reg));
  endproperty
  a_err: assert property (p_err) else $error("error summary without cause");

  property p_err_set;
    (|(src.error_enable_reg & src.error_flag_reg)) |-> summary[EIS_BIT_ERR];
  endproperty
  a_err_set: assert property (p_err_set) else $error("error summary missing");

  property p_sent;
    summary[EIS_BIT_SENT] == (|(src.frame_sent_enable & src.frame_sent_flag));
  endproperty
  a_sent: assert property (p_sent) else $error("frame sent summary wrong");

  property p_got;
    summary[EIS_BIT_GOT] == (|(src.frame_got_enable & src.frame_got_flag));
  endproperty
  a_got: assert property (p_got) else $error("frame got summary wrong");

  property p_count;
    timeout_event && !cnt_clear && count != CNT_TOP |=> count == $past(count) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("time-out not counted");

  // the counter moves only on a time-out or a clear, never on its own
  property p_hold;
    !timeout_event && !cnt_clear |=> count == $past(count);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without cause");

  // the time-out event must survive a status read in the same cycle
  property p_to_evt;
    cnt_step |=> evt_stat[EIS_EVT_TIMEOUT];
  endproperty
  a_to_evt: assert property (p_to_evt) else $error("time-out event lost");

  property p_sat;
    count == CNT_TOP && !cnt_clear |=> count == CNT_TOP;
  endproperty
  a_sat: assert property (p_sat) else $error("counter left saturation");

  property p_clr_rd;
    clear_mode && rd_cnt && !timeout_event |=> count == '0;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("read did not clear counter");

  property p_rd_val;
    rd_cnt |=> hrdata[CNT_W-1:0] == $past(count);
  endproperty
  a_rd_val: assert property (p_rd_val) else $error("counter read value wrong");

  property p_keep_rd;
    !clear_mode && rd_cnt && !timeout_event && !wr_cnt |=> count == $past(count);
  endproperty
  a_keep_rd: assert property (p_keep_rd) else $error("read changed counter");

  property p_clr_wr;
    !clear_mode && wr_cnt && !timeout_event |=> count == '0;
  endproperty
  a_clr_wr: assert property (p_clr_wr) else $error("write did not clear counter");

  property p_hi_zero;
    rd_cnt |=> hrdata[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("counter upper bits nonzero");

  property p_live;
    rd_sum |=> hrdata == $past(summary);
  endproperty
  a_live: assert property (p_live) else $error("summary read not live");

  // with every source quiet nothing may be set in the summary
  property p_sum_idle;
    src == '0 |-> summary == 32'h0000_0000;
  endproperty
  a_sum_idle: assert property (p_sum_idle) else $error("summary set with quiet sources");

  c_sat:    cover property (count == CNT_TOP && timeout_event);
  c_clr_rd: cover property (rd_cnt_q && clear_mode && count == '0);
  c_irq:    cover property (!irq ##1 irq);
  c_desc:   cover property (rd_sum ##1 hrdata[EIS_DESC_HI]);
  c_pend:   cover property (evt_set[EIS_EVT_PENDING] && evt_mask[EIS_EVT_PENDING]);

endmodule
`default_nettype wire

// >>> test_ethernet_irq_summary_and_timeout_count.sv
/*
  test_ethernet_irq_summary_and_timeout_count: self-checking bench for
  eis_irq_summary, driving its ahb-lite port, sources and time-out pulse.
  assumes: eis_pkg compiled first; assertions live in the design files.
*/
`timescale 1ns/100ps
`default_nettype none
module test_ethernet_irq_summary_and_timeout_count;
  import eis_pkg::*;
  // short counter so saturation is reached in a few pulses
  localparam int CNT_W = 4;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic        timeout_event;
  logic        irq;
  eis_src_s    src;
  int          failures;
  int          tests_run;

  eis_irq_summary #(.CNT_W(CNT_W)) eis_irq_summary_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src(src),
    .timeout_event(timeout_event), .irq(irq)
  );

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded so a stuck hreadyout cannot hang the task itself
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 16) begin
      n++;
      @(posedge hclk);
    end
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ofs};
    hwrite <= 1'b0;
    htrans <= EIS_HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    wait_ready();
    d = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ofs};
    hwrite <= 1'b1;
    htrans <= EIS_HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_ready();
    hwrite <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(ofs, d);
    check(what, d, exp);
  endtask

  // event status read, only the bits named in m are compared
  task automatic evt(input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    rd(EIS_OFS_EVT_STAT, d);
    check("event status", d & m, exp);
  endtask

  task automatic sum(input eis_src_s s, input logic [31:0] exp);
    @(posedge hclk);
    src <= s;
    rdc(EIS_OFS_SUMMARY, exp, "summary");
  endtask

  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      timeout_event <= 1'b1;
      @(posedge hclk);
      timeout_event <= 1'b0;
    end
  endtask

  task automatic irq_is(input logic exp);
    @(posedge hclk);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // the whole run needs a few hundred cycles; this 5000-cycle limit is over ten times that
  initial begin
    #50000;
    failures++;
    test_done();
  end

  initial begin
    eis_src_s s;
    failures = 0;
    tests_run = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    timeout_event = 1'b0;
    src = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(EIS_OFS_SUMMARY, 32'h0, "summary reset");
    rdc(EIS_OFS_COUNTER, 32'h0, "counter reset");
    rdc(EIS_OFS_CONTROL, 32'h0, "control reset");
    rdc(EIS_OFS_EVT_MASK, 32'h0, "mask reset");
    rdc(8'h20, 32'h0, "unmapped");
    check("hresp", {31'h0, hresp}, 32'h0);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    // counter in clear-on-write mode
    pulse(3);
    rdc(EIS_OFS_COUNTER, 32'h3, "count");
    rdc(EIS_OFS_COUNTER, 32'h3, "count after read");
    wr(EIS_OFS_COUNTER, 32'h0000_A5C3);
    rdc(EIS_OFS_COUNTER, 32'h0, "count after write");
    // interrupt masked, then unmasked, then cleared by read
    evt(32'hFFFF_FFFF, 32'h2);
    pulse(1);
    irq_is(1'b0);
    evt(32'h2, 32'h2);
    evt(32'h2, 32'h0);
    wr(EIS_OFS_EVT_MASK, 32'h6);
    pulse(1);
    irq_is(1'b1);
    evt(32'h2, 32'h2);
    irq_is(1'b0);
    // saturation at the shortened maximum
    pulse(20);
    rdc(EIS_OFS_COUNTER, 32'h0000_000F, "saturated");
    irq_is(1'b1);
    evt(32'h4, 32'h4);
    wr(EIS_OFS_COUNTER, 32'h0);
    // clear-on-read mode
    wr(EIS_OFS_CONTROL, 32'h1);
    rdc(EIS_OFS_CONTROL, 32'h1, "control");
    pulse(2);
    wr(EIS_OFS_COUNTER, 32'h0);
    rdc(EIS_OFS_COUNTER, 32'h2, "count read clear");
    rdc(EIS_OFS_COUNTER, 32'h0, "count cleared");
    // summary sources, one pair at a time, and all of them at once
    for (int i = 1; i < 16; i++) begin
      s = '0;
      s.descriptor_enable_reg[i] = 1'b1;
      s.descriptor_flag_reg[i] = 1'b1;
      sum(s, 32'h1 << (16 + i));
      s.descriptor_flag_reg[i] = 1'b0;
      s.descriptor_flag_reg[(i % 15) + 1] = 1'b1;
      sum(s, 32'h0);
    end
    s = '0;
    s.descriptor_enable_reg[0] = 1'b1;
    s.descriptor_flag_reg[0] = 1'b1;
    sum(s, 32'h0);
    sum('1, 32'hFFFE_33C5);
    s = '0;
    s.time_sync_flag_reg[31] = 1'b1;
    sum(s, 32'h0000_2000);
    s = '0;
    s.time_sync_enable_reg[0] = 1'b1;
    sum(s, 32'h0000_2000);
    s = '0;
    s.rx_fifo_warn_enable = 1'b1;
    sum(s, 32'h0);
    s.rx_fifo_warn_flag = 1'b1;
    sum(s, 32'h0000_1000);
    s = '0;
    s.stamp_fifo_warn_enable = 1'b1;
    s.stamp_fifo_warn_flag = 1'b1;
    sum(s, 32'h0000_0200);
    s = '0;
    s.stamp_fifo_update_enable = 1'b1;
    s.stamp_fifo_update_flag = 1'b1;
    sum(s, 32'h0000_0100);
    s = '0;
    s.mac_core_irq = 1'b1;
    sum(s, 32'h0000_0080);
    s = '0;
    s.error_enable_reg[5] = 1'b1;
    s.error_flag_reg[6] = 1'b1;
    sum(s, 32'h0);
    s.error_flag_reg[5] = 1'b1;
    sum(s, 32'h0000_0040);
    s = '0;
    s.frame_sent_enable[3] = 1'b1;
    s.frame_sent_flag[2] = 1'b1;
    sum(s, 32'h0);
    s.frame_sent_flag[3] = 1'b1;
    sum(s, 32'h0000_0004);
    s = '0;
    s.frame_got_enable[17] = 1'b1;
    s.frame_got_flag[16] = 1'b1;
    sum(s, 32'h0);
    s.frame_got_flag[17] = 1'b1;
    sum(s, 32'h0000_0001);
    wr(EIS_OFS_SUMMARY, 32'hFFFF_FFFF);
    sum(s, 32'h0000_0001);
    // pending event: summary went nonzero during the source walk
    evt(32'h1, 32'h1);
    wr(EIS_OFS_EVT_MASK, 32'h1);
    sum('0, 32'h0);
    irq_is(1'b0);
    sum(s, 32'h0000_0001);
    irq_is(1'b1);
    test_done();
  end
endmodule
`default_nettype wire
